/* verilog/mpsj_consts.svh */
// Constants for the microprogram sequencer branch logic.
`ifndef MPSJ_CONSTS_SVH
`define MPSJ_CONSTS_SVH
`define MPSJ_LC_W          11
`define MPSJ_MW_W          16
`define MPSJ_LC_RST        11'h000
`define MPSJ_RR_RST        11'h000
`define MPSJ_PAGE_LSB      8
// Opcode field positions in the microword.
`define MPSJ_OP_HI         15
`define MPSJ_OP_LO         8
// Opcode bits 15:8 for each group (octal 000000 etc. shifted right by 8).
`define MPSJ_OP_JMP_MAX    8'h07
`define MPSJ_OP_RFS_MIN    8'h08
`define MPSJ_OP_RFS_MAX    8'h0f
`define MPSJ_OP_ZB_CLR     8'h10
`define MPSJ_OP_ZB_SET     8'h11
`define MPSJ_OP_C8_CLR     8'h12
`define MPSJ_OP_C8_SET     8'h13
`define MPSJ_OP_IC_CLR     8'h14
`define MPSJ_OP_IC_SET     8'h15
`define MPSJ_OP_NB_CLR     8'h16
`define MPSJ_OP_NB_SET     8'h17
`define MPSJ_OP_Z_CLR      8'h18
`define MPSJ_OP_Z_SET      8'h19
`define MPSJ_OP_V_CLR      8'h1c
`define MPSJ_OP_N_CLR      8'h1e
`define MPSJ_OP_N_SET      8'h1f
`endif

/* verilog/mpsj_pkg.sv */
// Types for the microprogram sequencer branch logic.
package mpsj_pkg;
   typedef enum logic [2:0] {
      MPSJ_BR_NONE = 3'b001,
      MPSJ_BR_ABS  = 3'b010,
      MPSJ_BR_PAGE = 3'b100
   } mpsj_br_e;
   typedef enum logic [1:0] {
      MPSJ_ST_RUN  = 2'b01,
      MPSJ_ST_SEC  = 2'b10
   } mpsj_st_e;
endpackage : mpsj_pkg

/* verilog/mpsj_dec_if.sv */
// Interface carrying the decoded branch request between decoder and sequencer.
`timescale 1ns/1ps
interface mpsj_dec_if;
   logic              is_branch;
   logic              is_jump;
   logic              is_return;
   logic              is_cond;
   logic              taken;
   modport dec (output is_branch, output is_jump, output is_return, output is_cond, output taken);
   modport seq (input is_branch, input is_jump, input is_return, input is_cond, input taken);
endinterface : mpsj_dec_if

/* verilog/mpsj_decode.sv */
// Combinational opcode decoder and condition evaluator.
`timescale 1ns/1ps
`include "mpsj_consts.svh"
module mpsj_decode (
   input  wire logic [15:0] op_word_i,           // Microword being decoded.
   input  wire logic        byte_zero_bit_i,     // Byte-zero status bit.
   input  wire logic        byte_negative_bit_i, // Byte-negative status bit.
   input  wire logic        byte_carry_out_bit_i,// Byte carry-out status bit.
   input  wire logic        indirect_cond_code_i,// Indirect condition code.
   input  wire logic        cc_n_i,              // Negative condition code.
   input  wire logic        cc_z_i,              // Zero condition code.
   input  wire logic        cc_v_i,              // Overflow condition code.
   mpsj_dec_if.dec          dec                  // Decoded request.
);
   logic [7:0] op;
   assign op = op_word_i[`MPSJ_OP_HI:`MPSJ_OP_LO];
   // Group decode by the upper opcode byte.
   always_comb begin
      dec.is_jump   = (op <= `MPSJ_OP_JMP_MAX);
      dec.is_return = (op >= `MPSJ_OP_RFS_MIN) && (op <= `MPSJ_OP_RFS_MAX);
      dec.is_cond   = 1'b1;
      dec.taken     = 1'b0;
      case (op)
         `MPSJ_OP_ZB_CLR: dec.taken = ~byte_zero_bit_i;
         `MPSJ_OP_ZB_SET: dec.taken = byte_zero_bit_i;
         `MPSJ_OP_NB_CLR: dec.taken = ~byte_negative_bit_i;
         `MPSJ_OP_NB_SET: dec.taken = byte_negative_bit_i;
         `MPSJ_OP_IC_CLR: dec.taken = ~indirect_cond_code_i;
         `MPSJ_OP_IC_SET: dec.taken = indirect_cond_code_i;
         `MPSJ_OP_C8_CLR: dec.taken = ~byte_carry_out_bit_i;
         `MPSJ_OP_C8_SET: dec.taken = byte_carry_out_bit_i;
         `MPSJ_OP_N_CLR:  dec.taken = ~cc_n_i;
         `MPSJ_OP_N_SET:  dec.taken = cc_n_i;
         `MPSJ_OP_Z_CLR:  dec.taken = ~cc_z_i;
         `MPSJ_OP_Z_SET:  dec.taken = cc_z_i;
         `MPSJ_OP_V_CLR:  dec.taken = ~cc_v_i;
         default:         dec.is_cond = 1'b0;
      endcase
      dec.is_branch = dec.is_jump | dec.is_return | dec.is_cond;
   end
endmodule : mpsj_decode

/* verilog/mpsj_sequencer.sv */
// Location counter sequencing for jump, return and conditional jump microinstructions.
// Summary of operation
// - Jump opcodes 000000-003777 load microword bits 10:0 into the location counter.
// - Every jump, return and conditional jump takes two microcycles.
// - Jump and return ignore any translation array address.
// - Branches change only the location counter, plus the return register on a jump.
// - Return opcodes 004000-007777 load the return register into the location counter.
// - The return register is captured when an unconditional jump executes.
// - Taken conditional jump replaces counter bits 7:0 only; page bits stay.
// - The page is fixed when the sequential address loads in microcycle one.
// - A failed test keeps the already loaded sequential address.
// - Conditional jumps ignore translation array bits 7:0.
// - 010000-010377 branch on byte zero clear; 010400-010777 on set.
// - 013000-013377 branch on byte negative clear; 013400-013777 on set.
// - 012000-012377 branch when the indirect condition code is zero.
// - A modify step before a jump lets a register supply the target.
// - 012400-012777 branch when the indirect condition code is one.
// - 011000-011377 branch on carry-out clear; 011400-011777 on set.
// - 017000/017400 test negative code; 014000/014400 test zero code.
// - 016000-016377 branch when the overflow code is clear.
`timescale 1ns/1ps
`include "mpsj_consts.svh"
module mpsj_sequencer (
   input  wire logic                     core_clk_i,           // System clock, 100 MHz.
   input  wire logic                     rst_n_i,              // Asynchronous reset, active low.
   input  wire logic                     ucyc_en_i,            // One-cycle pulse per microcycle.
   input  wire logic [`MPSJ_MW_W-1:0]    microword_field_i,    // Fetched microword.
   input  wire logic                     modify_valid_i,       // Modify step supplied a register word.
   input  wire logic [`MPSJ_MW_W-1:0]    modify_word_i,        // Register word merged into the microword.
   input  wire logic                     xlat_valid_i,         // Translation array hit.
   input  wire logic [`MPSJ_LC_W-1:0]    xlat_addr_i,          // Translation array address.
   input  wire logic                     byte_zero_bit_i,      // Byte-zero status bit.
   input  wire logic                     byte_negative_bit_i,  // Byte-negative status bit.
   input  wire logic                     byte_carry_out_bit_i, // Byte carry-out status bit.
   input  wire logic                     indirect_cond_code_i, // Indirect condition code.
   input  wire logic                     cc_n_i,               // Negative condition code.
   input  wire logic                     cc_z_i,               // Zero condition code.
   input  wire logic                     cc_v_i,               // Overflow condition code.
   output logic [`MPSJ_LC_W-1:0]         location_counter_o,   // Next fetch address.
   output logic [`MPSJ_LC_W-1:0]         return_register_o,    // Saved return address.
   output logic                          branch_busy_o,        // High in the second branch microcycle.
   output logic                          data_hold_o           // Block data, flag and code writes.
);
   import mpsj_pkg::*;

   mpsj_dec_if dif ();
   logic [`MPSJ_MW_W-1:0] word_eff;
   logic [`MPSJ_LC_W-1:0] lc_r, lc_nxt, rr_r, rr_nxt, seq_addr;
   logic [`MPSJ_LC_W-1:0] tgt_r, tgt_nxt;
   mpsj_br_e              br_r, br_nxt;
   mpsj_st_e              st_r, st_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // A modify step ORs a register word into the microword so the jump target can
   // come from a register; without it the microword is used as fetched.
   assign word_eff = modify_valid_i ? (microword_field_i | modify_word_i) : microword_field_i;

   mpsj_decode u_dec (
      .op_word_i            (word_eff),
      .byte_zero_bit_i      (byte_zero_bit_i),
      .byte_negative_bit_i  (byte_negative_bit_i),
      .byte_carry_out_bit_i (byte_carry_out_bit_i),
      .indirect_cond_code_i (indirect_cond_code_i),
      .cc_n_i               (cc_n_i),
      .cc_z_i               (cc_z_i),
      .cc_v_i               (cc_v_i),
      .dec                  (dif)
   );

   // Sequential address, wrapping inside the 11-bit space.
   assign seq_addr = lc_r + 11'h001;

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic. First microcycle loads the sequential address (fixing the
   // page) and latches the target; the second microcycle applies it.
   always_comb begin
      lc_nxt  = lc_r;
      rr_nxt  = rr_r;
      tgt_nxt = tgt_r;
      br_nxt  = br_r;
      st_nxt  = st_r;
      if (ucyc_en_i) begin
         case (st_r)
            MPSJ_ST_RUN: begin
               lc_nxt = seq_addr;
               if (dif.is_branch) begin
                  st_nxt = MPSJ_ST_SEC;
                  br_nxt = MPSJ_BR_NONE;
                  if (dif.is_jump) begin
                     tgt_nxt = word_eff[`MPSJ_LC_W-1:0];
                     br_nxt  = MPSJ_BR_ABS;
                     rr_nxt  = seq_addr;
                  end else if (dif.is_return) begin
                     tgt_nxt = rr_r;
                     br_nxt  = MPSJ_BR_ABS;
                  end else if (dif.taken) begin
                     tgt_nxt = {seq_addr[`MPSJ_LC_W-1:`MPSJ_PAGE_LSB], word_eff[7:0]};
                     br_nxt  = MPSJ_BR_PAGE;
                  end
               end else if (xlat_valid_i) begin
                  // Translation only steers ordinary microinstructions.
                  lc_nxt = xlat_addr_i;
               end
            end
            MPSJ_ST_SEC: begin
               st_nxt = MPSJ_ST_RUN;
               case (br_r)
                  MPSJ_BR_ABS:  lc_nxt = tgt_r;
                  MPSJ_BR_PAGE: lc_nxt = tgt_r;
                  MPSJ_BR_NONE: lc_nxt = lc_r;
                  default:      lc_nxt = lc_r;
               endcase
            end
            default: st_nxt = MPSJ_ST_RUN;
         endcase
      end
   end

   // State registers; translation input never reaches them during a branch.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lc_r  <= `MPSJ_LC_RST;
         rr_r  <= `MPSJ_RR_RST;
         tgt_r <= `MPSJ_LC_RST;
         br_r  <= MPSJ_BR_NONE;
         st_r  <= MPSJ_ST_RUN;
      end else begin
         lc_r  <= lc_nxt;
         rr_r  <= rr_nxt;
         tgt_r <= tgt_nxt;
         br_r  <= br_nxt;
         st_r  <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs. Data hold stops the data unit from writing registers or flags while
   // a branch-class word is executing, in both microcycles.
   assign location_counter_o = lc_r;
   assign return_register_o  = rr_r;
   assign branch_busy_o      = (st_r == MPSJ_ST_SEC);
   assign data_hold_o        = branch_busy_o | dif.is_branch;
endmodule : mpsj_sequencer

/* verification/mpsj_seq_asserts.sv */
// Checker for the branch sequencing seen at the sequencer's ports.
`timescale 1ns/1ps
module mpsj_seq_asserts (
   input  wire logic        core_clk_i,         // Clock.
   input  wire logic        rst_n_i,            // Reset, active low.
   input  wire logic        ucyc_en_i,          // Microcycle strobe.
   input  wire logic [15:0] microword_field_i,  // Fetched microword.
   input  wire logic        modify_valid_i,     // Modify step valid.
   input  wire logic [15:0] modify_word_i,      // Modify word.
   input  wire logic        xlat_valid_i,       // Translation hit.
   input  wire logic [10:0] location_counter_o, // Fetch address.
   input  wire logic [10:0] return_register_o,  // Saved return address.
   input  wire logic        branch_busy_o,      // Second branch microcycle.
   input  wire logic        data_hold_o         // Data state hold.
);
   logic [15:0] mw;
   logic [10:0] seq, tgt_r;
   logic [1:0]  kind_r;
   logic        go, jump_always, return_from_sub, cnd;
   // Decode the merged word the way the sequencer sees it at launch.
   assign mw  = microword_field_i | (modify_valid_i ? modify_word_i : 16'h0000);
   assign go  = ucyc_en_i & ~branch_busy_o;
   assign jump_always = mw[15:8] <= 8'h07;
   assign return_from_sub = mw[15:11] == 5'h01;
   assign cnd = mw[15:8] inside {[8'h10:8'h19], 8'h1c, 8'h1e, 8'h1f};
   assign seq = location_counter_o + 11'h001;
   // Remember the kind and target at launch; the page comes from the sequential address.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         kind_r <= 2'h0;
         tgt_r  <= 11'h000;
      end else if (go) begin
         kind_r <= {return_from_sub | cnd, jump_always | cnd};
         tgt_r  <= jump_always ? mw[10:0] : (return_from_sub ? return_register_o : {seq[10:8], 8'h00});
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_branch_goes_busy: assert property (go && (jump_always || return_from_sub || cnd) |=> branch_busy_o) else $error("busy missing");
   a_busy_one_cycle: assert property (branch_busy_o && ucyc_en_i |=> !branch_busy_o) else $error("busy too long");
   a_seq_first_cycle: assert property (
      go && (jump_always || return_from_sub || cnd) |=> location_counter_o == $past(seq))
      else $error("first cycle address wrong");
   a_jump_target_load: assert property (
      $fell(branch_busy_o) && kind_r == 2'h1 |-> location_counter_o == tgt_r)
      else $error("jump target wrong");
   a_return_target_load: assert property (
      $fell(branch_busy_o) && kind_r == 2'h2 |-> location_counter_o == tgt_r)
      else $error("return target wrong");
   a_cond_page_kept: assert property (
      $fell(branch_busy_o) && kind_r == 2'h3 |-> location_counter_o[10:8] == tgt_r[10:8])
      else $error("page changed");
   a_return_reg_load: assert property (
      go && jump_always |=> return_register_o == $past(seq)) else $error("rr not captured");
   a_plain_advance: assert property (
      go && !(jump_always || return_from_sub || cnd) && !xlat_valid_i |=> location_counter_o == $past(seq))
      else $error("no advance");
   a_hold_in_branch: assert property (branch_busy_o |-> data_hold_o) else $error("data not held");
   c_jump: cover property (go && jump_always);
   c_return: cover property (go && return_from_sub);
   c_cond: cover property (go && cnd);
endmodule : mpsj_seq_asserts
bind mpsj_sequencer mpsj_seq_asserts u_asserts (.core_clk_i, .rst_n_i, .ucyc_en_i, .microword_field_i,
   .modify_valid_i, .modify_word_i, .xlat_valid_i, .location_counter_o, .return_register_o, .branch_busy_o, .data_hold_o);

/* verification/mpsj_ustore_model.sv */
// Behavioural microcode store answering the location counter with a microword.
`timescale 1ns/1ps
module mpsj_ustore_model (
   input  wire logic        core_clk_i, // Clock.
   input  wire logic        wr_en_i,    // Load strobe.
   input  wire logic [10:0] wr_addr_i,  // Load address.
   input  wire logic [15:0] wr_data_i,  // Load word.
   input  wire logic [10:0] addr_i,     // Fetch address.
   output logic      [15:0] word_o      // Fetched word.
);
   logic [15:0] mem [2048];
   // Empty places hold a data word, so a stray fetch never branches.
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 16'hf000;
      end
   end
   // Loads are clocked so a fetch never sees a half-written word.
   always @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end
   assign word_o = mem[addr_i];
endmodule : mpsj_ustore_model

/* verification/test_microprogram_sequencer_jumps.sv */
// Self-checking bench for jump, return and conditional jump sequencing.
`timescale 1ns/1ps
module test_microprogram_sequencer_jumps;
   logic        core_clk_i, rst_n_i, ucyc, mval, xval, wr, busy, hold, b;
   logic [15:0] word, mword, wdat;
   logic [10:0] lc, rr, xadr, wadr, e;
   logic [6:0]  f, fv;
   int          n_errors, num_checks;
   logic [7:0]  ops [13] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1c, 8'h1e, 8'h1f};
   int          ix [13] = '{6, 6, 4, 4, 3, 3, 5, 5, 1, 1, 0, 2, 2};
   mpsj_ustore_model u_store (.core_clk_i, .wr_en_i(wr), .wr_addr_i(wadr), .wr_data_i(wdat), .addr_i(lc), .word_o(word));
   mpsj_sequencer dut (.core_clk_i, .rst_n_i, .ucyc_en_i(ucyc), .microword_field_i(word), .modify_valid_i(mval),
      .modify_word_i(mword), .xlat_valid_i(xval), .xlat_addr_i(xadr), .byte_zero_bit_i(f[6]), .byte_negative_bit_i(f[5]),
      .byte_carry_out_bit_i(f[4]), .indirect_cond_code_i(f[3]), .cc_n_i(f[2]), .cc_z_i(f[1]), .cc_v_i(f[0]),
      .location_counter_o(lc), .return_register_o(rr), .branch_busy_o(busy), .data_hold_o(hold));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare one value and count it.
   task automatic chk(input string nm, input logic [10:0] s, input logic [10:0] x);
      num_checks++;
      if (s !== x) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   // Load one word into the store; a clocked write keeps fetches clean.
   task automatic ld(input logic [10:0] a, input logic [15:0] w);
      @(posedge core_clk_i);
      wr   <= 1'b1;
      wadr <= a;
      wdat <= w;
      @(posedge core_clk_i);
      wr   <= 1'b0;
   endtask : ld
   // Run one microcycle, then check where the counter stands.
   task automatic uc(input logic [10:0] x);
      @(posedge core_clk_i);
      ucyc <= 1'b1;
      @(posedge core_clk_i);
      ucyc <= 1'b0;
      #1 chk("location counter", lc, x);
   endtask : uc
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // Main sequence; translation is held active around the jump and conditional jumps to prove it is ignored.
   initial begin
      {rst_n_i, ucyc, mval, wr, f, mword, wadr, wdat} = '0;
      xval = 1'b1;
      xadr = 11'h555;
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      ld(11'h000, 16'h00fe);
      uc(11'h001);
      uc(11'h0fe);
      chk("return register", rr, 11'h001);
      xval <= 1'b0;
      $display("jump test done");
      ld(11'h0fe, 16'hf000);
      ld(11'h0ff, 16'h1034);
      ld(11'h134, 16'h0800);
      uc(11'h0ff);
      uc(11'h100);
      uc(11'h134);
      uc(11'h135);
      uc(11'h001);
      $display("page and return test done");
      ld(11'h001, 16'h0400);
      mval  <= 1'b1;
      mword <= 16'h03ff;
      uc(11'h002);
      mval  <= 1'b0;
      uc(11'h7ff);
      uc(11'h000);
      $display("modify and wrap test done");
      xval <= 1'b1;
      e = 11'h000;
      // Even passes meet the condition on the tested flag only; odd passes miss it.
      // Targets sit well ahead of the sequential address so a taken jump is visible.
      for (int i = 0; i < 26; i++) begin
         ld(e, {ops[i/2], 8'h80 + 8'(4 * i)});
         b = ops[i/2][0] ^ i[0];
         fv = {7{~b}};
         fv[ix[i/2]] = b;
         f <= fv;
         uc(e + 11'h001);
         e = e + 11'h001;
         if (!i[0]) e = {e[10:8], 8'h80 + 8'(4 * i)};
         uc(e);
      end
      $display("condition table test done");
      tally_and_finish();
   end
endmodule : test_microprogram_sequencer_jumps
